// ==== hw/wdps_period_select.sv ====
`timescale 1ns/1ns
module wdps_period_select #(
	parameter int unsigned REF_DIV_CYCLES = wdps_pkg::WDPS_REF_DIV_CYCLES
) (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic [wdps_pkg::WDPS_FIELD_MSB:wdps_pkg::WDPS_FIELD_LSB] wdt_period_config_field,
	input wire logic sw_period_we,
	input wire wdps_pkg::wdps_code_t sw_period_wdata,
	input wire logic wdt_clear,
	output wdps_pkg::wdps_code_t wdt_live_period_setting,
	output logic period_sw_controlled,
	output logic period_ready,
	output logic [4:0] divider_exponent,
	output wdps_pkg::wdps_count_t prescale_count,
	output logic ref_tick,
	output logic period_timeout,
	output logic sw_write_refused
);
	import wdps_pkg::*;

	typedef struct packed {
		wdps_code_t cfg_meta;
		wdps_code_t cfg_sync;
		wdps_state_t state;
		wdps_code_t live;
		logic sw_mode;
		logic ready;
		logic [4:0] exp;
		wdps_count_t count;
		logic timeout;
		logic refused;
	} wdps_regs_t;

	localparam wdps_regs_t RESET_VALUE = '{
		cfg_meta: WDPS_CODE_ERASED,
		cfg_sync: WDPS_CODE_ERASED,
		state: WDPS_ST_SYNC,
		live: WDPS_CODE_SW_DEFAULT,
		sw_mode: 1'b1,
		ready: 1'b0,
		exp: WDPS_CODE_SW_DEFAULT + WDPS_EXP_OFFSET,
		count: '0,
		timeout: 1'b0,
		refused: 1'b0
	};

	wdps_regs_t r;
	wdps_regs_t next_r;
	logic tick;
	wdps_count_t last_count;
	logic write_taken;
	logic count_end;

	// one line per code; codes past the top ratio fall back to the shortest
	function automatic logic [4:0] code_to_exp(input wdps_code_t code);
		logic [4:0] e;
		e = WDPS_EXP_MIN;
		unique case (code)
			5'h00: e = 5'h00 + WDPS_EXP_OFFSET;
			5'h01: e = 5'h01 + WDPS_EXP_OFFSET;
			5'h02: e = 5'h02 + WDPS_EXP_OFFSET;
			5'h03: e = 5'h03 + WDPS_EXP_OFFSET;
			5'h04: e = 5'h04 + WDPS_EXP_OFFSET;
			5'h05: e = 5'h05 + WDPS_EXP_OFFSET;
			5'h06: e = 5'h06 + WDPS_EXP_OFFSET;
			5'h07: e = 5'h07 + WDPS_EXP_OFFSET;
			5'h08: e = 5'h08 + WDPS_EXP_OFFSET;
			5'h09: e = 5'h09 + WDPS_EXP_OFFSET;
			5'h0a: e = 5'h0a + WDPS_EXP_OFFSET;
			5'h0b: e = 5'h0b + WDPS_EXP_OFFSET;
			5'h0c: e = 5'h0c + WDPS_EXP_OFFSET;
			5'h0d: e = 5'h0d + WDPS_EXP_OFFSET;
			5'h0e: e = 5'h0e + WDPS_EXP_OFFSET;
			5'h0f: e = 5'h0f + WDPS_EXP_OFFSET;
			5'h10: e = 5'h10 + WDPS_EXP_OFFSET;
			5'h11: e = 5'h11 + WDPS_EXP_OFFSET;
			5'h12: e = 5'h12 + WDPS_EXP_OFFSET;
			5'h13: e = WDPS_EXP_MIN;
			5'h14: e = WDPS_EXP_MIN;
			5'h15: e = WDPS_EXP_MIN;
			5'h16: e = WDPS_EXP_MIN;
			5'h17: e = WDPS_EXP_MIN;
			5'h18: e = WDPS_EXP_MIN;
			5'h19: e = WDPS_EXP_MIN;
			5'h1a: e = WDPS_EXP_MIN;
			5'h1b: e = WDPS_EXP_MIN;
			5'h1c: e = WDPS_EXP_MIN;
			5'h1d: e = WDPS_EXP_MIN;
			5'h1e: e = WDPS_EXP_MIN;
			WDPS_CODE_SW: e = WDPS_EXP_MIN;
		endcase
		return e;
	endfunction

	// software keeps control of the period only for the erased code
	function automatic logic code_sw_control(input wdps_code_t code);
		logic sw;
		sw = 1'b0;
		unique case (code)
			5'h00: sw = 1'b0;
			5'h01: sw = 1'b0;
			5'h02: sw = 1'b0;
			5'h03: sw = 1'b0;
			5'h04: sw = 1'b0;
			5'h05: sw = 1'b0;
			5'h06: sw = 1'b0;
			5'h07: sw = 1'b0;
			5'h08: sw = 1'b0;
			5'h09: sw = 1'b0;
			5'h0a: sw = 1'b0;
			5'h0b: sw = 1'b0;
			5'h0c: sw = 1'b0;
			5'h0d: sw = 1'b0;
			5'h0e: sw = 1'b0;
			5'h0f: sw = 1'b0;
			5'h10: sw = 1'b0;
			5'h11: sw = 1'b0;
			5'h12: sw = 1'b0;
			5'h13: sw = 1'b0;
			5'h14: sw = 1'b0;
			5'h15: sw = 1'b0;
			5'h16: sw = 1'b0;
			5'h17: sw = 1'b0;
			5'h18: sw = 1'b0;
			5'h19: sw = 1'b0;
			5'h1a: sw = 1'b0;
			5'h1b: sw = 1'b0;
			5'h1c: sw = 1'b0;
			5'h1d: sw = 1'b0;
			5'h1e: sw = 1'b0;
			WDPS_CODE_SW: sw = 1'b1;
		endcase
		return sw;
	endfunction

	// ones below the exponent give the terminal count 2^e-1
	for (genvar b = 0; b < WDPS_COUNT_W; b++) begin : g_last
		assign last_count[b] = (b < r.exp);
	end

	// an accepted write restarts the period, so its tick is dropped
	assign write_taken = sw_period_we && r.sw_mode;
	assign count_end = r.count >= last_count;

	wdps_ref_tick #(
		.DIV_CYCLES(REF_DIV_CYCLES)
	) wdps_ref_tick_i (
		.ref_clk(ref_clk),
		.resetn(resetn),
		.ref_tick(tick)
	);

	always_comb begin
		next_r = r;
		next_r.cfg_meta = wdt_period_config_field;
		next_r.cfg_sync = r.cfg_meta;
		next_r.timeout = 1'b0;
		next_r.refused = 1'b0;
		unique case (r.state)
			WDPS_ST_SYNC: begin
				next_r.state = WDPS_ST_LOAD;
			end
			WDPS_ST_LOAD: begin
				// field is static after reset; two stages settle it before capture
				next_r.sw_mode = code_sw_control(r.cfg_sync);
				if (code_sw_control(r.cfg_sync)) begin
					next_r.live = WDPS_CODE_SW_DEFAULT;
				end else begin
					next_r.live = r.cfg_sync;
				end
				next_r.count = '0;
				next_r.ready = 1'b1;
				next_r.state = WDPS_ST_RUN;
			end
			WDPS_ST_RUN: begin
				if (sw_period_we) begin
					if (r.sw_mode) begin
						next_r.live = sw_period_wdata;
						next_r.count = '0;
					end else begin
						next_r.refused = 1'b1;
					end
				end
				if (wdt_clear) begin
					next_r.count = '0;
				end else if (tick && !write_taken) begin
					if (count_end) begin
						next_r.count = '0;
						next_r.timeout = 1'b1;
					end else begin
						next_r.count = r.count + 1'b1;
					end
				end
			end
			default: begin
				next_r.state = WDPS_ST_SYNC;
			end
		endcase
		next_r.exp = code_to_exp(next_r.live);
		// synchroniser keeps sampling in reset so the load sees the real field
		if (!resetn) begin
			next_r = RESET_VALUE;
			next_r.cfg_meta = wdt_period_config_field;
			next_r.cfg_sync = r.cfg_meta;
		end
	end

	always_ff @(posedge ref_clk) begin
		r <= next_r;
	end

	assign wdt_live_period_setting = r.live;
	assign period_sw_controlled = r.sw_mode;
	assign period_ready = r.ready;
	assign divider_exponent = r.exp;
	assign prescale_count = r.count;
	assign ref_tick = tick;
	assign period_timeout = r.timeout;
	assign sw_write_refused = r.refused;
endmodule

// ==== hw/wdps_pkg.sv ====
package wdps_pkg;
	localparam int unsigned WDPS_CODE_W = 5;
	localparam int unsigned WDPS_FIELD_MSB = 4;
	localparam int unsigned WDPS_FIELD_LSB = 0;
	localparam int unsigned WDPS_COUNT_W = 23;
	localparam logic [4:0] WDPS_CODE_SW = 5'h1f;
	localparam logic [4:0] WDPS_CODE_SW_DEFAULT = 5'h0b;
	localparam logic [4:0] WDPS_CODE_ERASED = 5'h1f;
	localparam logic [4:0] WDPS_CODE_MAX = 5'h12;
	localparam logic [4:0] WDPS_CODE_MIN = 5'h00;
	localparam logic [4:0] WDPS_EXP_OFFSET = 5'h05;
	localparam logic [4:0] WDPS_EXP_MIN = 5'h05;
	localparam int unsigned WDPS_CLK_HZ = 250000000;
	localparam int unsigned WDPS_REF_HZ = 31000;
	localparam int unsigned WDPS_REF_DIV_CYCLES = WDPS_CLK_HZ / WDPS_REF_HZ;
	localparam int unsigned WDPS_REF_DIV_W = 14;
	typedef logic [WDPS_CODE_W-1:0] wdps_code_t;
	typedef logic [WDPS_COUNT_W-1:0] wdps_count_t;
	typedef enum logic [2:0] {
		WDPS_ST_SYNC = 3'b001,
		WDPS_ST_LOAD = 3'b010,
		WDPS_ST_RUN = 3'b100
	} wdps_state_t;
endpackage

// ==== hw/wdps_ref_tick.sv ====
`timescale 1ns/1ns
module wdps_ref_tick #(
	parameter int unsigned DIV_CYCLES = wdps_pkg::WDPS_REF_DIV_CYCLES
) (
	input wire logic ref_clk,
	input wire logic resetn,
	output logic ref_tick
);
	import wdps_pkg::*;
	typedef struct packed {
		logic [WDPS_REF_DIV_W-1:0] cnt;
		logic tick;
	} wdps_div_t;
	localparam logic [WDPS_REF_DIV_W-1:0] LAST = WDPS_REF_DIV_W'(DIV_CYCLES - 1);
	wdps_div_t r;
	wdps_div_t next_r;
	always_comb begin
		next_r = r;
		next_r.tick = 1'b0;
		if (r.cnt == LAST) begin
			next_r.cnt = '0;
			next_r.tick = 1'b1;
		end else begin
			next_r.cnt = r.cnt + 1'b1;
		end
	end
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end
	assign ref_tick = r.tick;
endmodule

// ==== sim/wdps_period_select_asserts.sv ====
`timescale 1ns/1ns
module wdps_period_select_asserts (
	input logic ref_clk,
	input logic resetn,
	input logic [4:0] wdt_period_config_field,
	input logic sw_period_we,
	input logic [4:0] sw_period_wdata,
	input logic [4:0] wdt_live_period_setting,
	input logic period_sw_controlled,
	input logic period_ready,
	input logic [4:0] divider_exponent,
	input logic [22:0] prescale_count,
	input logic period_timeout,
	input logic sw_write_refused
);
	wire [4:0] l = wdt_live_period_setting;
	wire [4:0] f = wdt_period_config_field;
	wire r = period_ready;
	wire w = sw_period_we && r;
	wire m = period_sw_controlled;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!resetn);
	a_load_value: assert property ($rose(r) |-> l == (f == 5'h1f ? 5'h0b : f)) else $error("load");
	a_sw_write: assert property (w && m |=> l == $past(sw_period_wdata)) else $error("write");
	a_fixed_hold: assert property (r && !m |=> $stable(l)) else $error("hold");
	a_write_refused: assert property (w && !m |=> sw_write_refused) else $error("refuse");
	a_mode_code: assert property (r |-> m == (f == 5'h1f)) else $error("mode");
	a_exp_map: assert property (r |-> divider_exponent == (l > 5'h12 ? 5'h05 : l + 5'h05)) else $error("exp");
	a_timeout_wrap: assert property (period_timeout |-> prescale_count == 23'h0) else $error("wrap");
endmodule
bind wdps_period_select wdps_period_select_asserts wdps_period_select_asserts_i (
	.ref_clk(ref_clk),
	.resetn(resetn),
	.wdt_period_config_field(wdt_period_config_field),
	.sw_period_we(sw_period_we),
	.sw_period_wdata(sw_period_wdata),
	.wdt_live_period_setting(wdt_live_period_setting),
	.period_sw_controlled(period_sw_controlled),
	.period_ready(period_ready),
	.divider_exponent(divider_exponent),
	.prescale_count(prescale_count),
	.period_timeout(period_timeout),
	.sw_write_refused(sw_write_refused)
);

// ==== sim/wdps_period_select_test.sv ====
`timescale 1ns/1ns
module wdps_period_select_test;
	logic ref_clk = 0, resetn = 0, sw_period_we = 0, wdt_clear = 0, period_sw_controlled, period_ready, ref_tick;
	logic period_timeout, sw_write_refused;
	logic [4:0] wdt_period_config_field = 0, sw_period_wdata = 0, wdt_live_period_setting, divider_exponent, f, v, e;
	logic [22:0] prescale_count;
	logic [31:0] s = 32'ha1db;
	int bad_count = 0, check_count = 0, i, k;
	// short divider keeps the longest timed period at 512 cycles, under the 600-cycle limit
	wdps_period_select #(.REF_DIV_CYCLES(4)) wdps_period_select_i (
		.ref_clk(ref_clk),
		.resetn(resetn),
		.wdt_period_config_field(wdt_period_config_field),
		.sw_period_we(sw_period_we),
		.sw_period_wdata(sw_period_wdata),
		.wdt_clear(wdt_clear),
		.wdt_live_period_setting(wdt_live_period_setting),
		.period_sw_controlled(period_sw_controlled),
		.period_ready(period_ready),
		.divider_exponent(divider_exponent),
		.prescale_count(prescale_count),
		.ref_tick(ref_tick),
		.period_timeout(period_timeout),
		.sw_write_refused(sw_write_refused)
	);
	always #2 ref_clk = ~ref_clk;
	function automatic logic [4:0] rnd();
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s[4:0];
	endfunction
	function automatic logic [4:0] ld(logic [4:0] c);
		return c == 5'h1f ? 5'h0b : c;
	endfunction
	task automatic chk(string n, logic [4:0] g, logic [4:0] x);
		check_count++;
		if (g !== x) begin
			bad_count++;
			$display("[FAIL] %s exp %h saw %h", n, x, g);
		end
	endtask
	task automatic final_report();
		$display("checks %0d bad %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic cyc(int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	initial begin
		// every code once, then random fields
		for (i = 0; i < 40; i++) begin
			f = i < 32 ? 5'(i) : rnd();
			resetn = 0;
			wdt_period_config_field = f;
			cyc(5);
			resetn = 1;
			for (k = 0; k < 9 && period_ready !== 1; k++) cyc(1);
			chk("ready", period_ready, 1);
			if (period_ready !== 1) final_report();
			chk("load", wdt_live_period_setting, ld(f));
			chk("mode", period_sw_controlled, f == 5'h1f);
			v = ld(f);
			sw_period_we = 1;
			// back-to-back writes, last one wins
			repeat (3) begin
				sw_period_wdata = rnd();
				cyc(1);
				v = f == 5'h1f ? sw_period_wdata : v;
				chk("live", wdt_live_period_setting, v);
				chk("refused", sw_write_refused, f != 5'h1f);
			end
			sw_period_we = 0;
			// spacing between two reference ticks, in clocks
			for (k = 0; k < 8 && ref_tick !== 1; k++) cyc(1);
			cyc(1);
			for (k = 1; k < 8 && ref_tick !== 1; k++) cyc(1);
			chk("tick", k, 4);
			wdt_clear = 1;
			cyc(1);
			wdt_clear = 0;
			e = v > 5'h12 ? 5'h05 : v + 5'h05;
			chk("exp", divider_exponent, e);
			for (k = 0; e < 8 && k < 600 && period_timeout !== 1; k++) cyc(1);
			if (e < 8) chk("period", k >= (4 << e) - 4 && k <= (4 << e) + 4, 1);
			if (e < 8 && period_timeout !== 1) final_report();
		end
		final_report();
	end
endmodule
